// *** tcorr_pkg.sv ***
// Shared constants, register map and state type of the temperature channel and correction block
package tcorr_pkg;
    localparam int          ADDR_W             = 10;
    localparam int          DATA_W             = 32;
    localparam logic [9:0]  ADDR_CH1_CONFIG    = 10'h000;
    localparam logic [9:0]  ADDR_CH2_CONFIG    = 10'h004;
    localparam logic [9:0]  ADDR_POST_CORR     = 10'h008;
    localparam logic [9:0]  ADDR_STATUS        = 10'h00C;
    localparam logic [9:0]  ADDR_TEMP_RESULT   = 10'h010;
    localparam logic [9:0]  ADDR_PRES_RESULT   = 10'h014;
    localparam logic [9:0]  ADDR_COEF_BASE     = 10'h100;
    localparam logic [1:0]  COEF_REGION        = 2'h1;
    localparam int          COEF_DEPTH         = 64;
    localparam int          COEF_AW            = 6;
    localparam int          COEF_W             = 16;
    localparam logic [7:0]  CFG_RESET          = 8'h00;
    localparam logic [31:0] POST_RESET         = 32'h0000_0000;
    localparam int          CFG_IDIO_BIT       = 7;
    localparam int          CFG_LOG_BIT        = 4;
    localparam int          CFG_SRC_LSB        = 2;
    localparam int          CFG_RANGE_LSB      = 0;
    localparam int          POST_DG1_LSB       = 0;
    localparam int          POST_DO1_LSB       = 8;
    localparam int          POST_DG2_LSB       = 16;
    localparam int          POST_DO2_LSB       = 24;
    localparam logic [1:0]  SRC_INT_DIODE      = 2'h0;
    localparam logic [1:0]  SRC_PIN_A          = 2'h1;
    localparam logic [1:0]  SRC_PIN_B          = 2'h2;
    localparam logic [1:0]  SRC_BRIDGE_CURRENT = 2'h3;
    localparam logic [5:0]  T1_BASE            = 6'h00;
    localparam logic [5:0]  T2_BASE            = 6'h08;
    localparam logic [5:0]  P1_BASE            = 6'h10;
    localparam logic [5:0]  P2_BASE            = 6'h20;
    localparam logic [5:0]  AUX_OFFSET         = 6'h04;
    localparam logic [1:0]  POLY_DEGREE        = 2'h3;
    localparam int          POLY_SHIFT         = 15;
    localparam int          AUX_SHIFT          = 14;
    localparam int          DGAIN_SHIFT        = 13;
    localparam logic [2:0]  PJOB_PER_CH        = 3'h3;
    localparam logic [2:0]  LAST_PJOB          = 3'h5;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CONVERT, ST_WAIT_RAW, ST_POLY_WAIT, ST_POLY_ACC, ST_AUX_WAIT, ST_AUX, ST_PUBLISH
    } state_t;
endpackage

// *** coef_if.sv ***
// Coefficient memory link between the register side, the engine and the memory
`timescale 1ns/1ns
interface coef_if;
    import tcorr_pkg::*;
    logic [COEF_AW-1:0] a_addr;
    logic               a_we;
    logic [COEF_W-1:0]  a_wdata;
    logic [COEF_W-1:0]  a_rdata;
    logic [COEF_AW-1:0] b_addr;
    logic [COEF_W-1:0]  b_rdata;

    modport mem  (input a_addr, a_we, a_wdata, b_addr, output a_rdata, b_rdata);
    modport user (output a_addr, a_we, a_wdata, b_addr, input a_rdata, b_rdata);
endinterface

// *** coef_ram.sv ***
// Two-port coefficient memory with registered read data
`timescale 1ns/1ns
module coef_ram
    import tcorr_pkg::*;
#(
    parameter int WIDTH = COEF_W,
    parameter int DEPTH = COEF_DEPTH
) (
    input  wire logic clk,
    coef_if.mem       port
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Port a writes and reads for software, port b reads for the engine
    always_ff @(posedge clk) begin
        if (port.a_we) begin
            mem[port.a_addr] <= port.a_wdata;
        end
        port.a_rdata <= mem[port.a_addr];
        port.b_rdata <= mem[port.b_addr];
    end
endmodule

// *** temp_channel_map.sv ***
// Temperature channel mapping, temperature linearization and pressure correction engine
// How it works
// - Each cycle converts logical channel one, then logical channel two, in order.
// - Channel one's corrected temperature alone drives the pressure coefficients.
// - Two-bit source code picks diode, pin a, pin b or bridge current.
// - Channel two uses a logarithmic input when its select bit is set.
// - Pin a gets a pull-down current for diodes; pin b gets none.
// - The channel two conversion always runs, even if nobody uses it.
// - Corrected pressure is a sum of coefficients over pressure and temperature powers.
// - Temperature first gives quadratic coefficients, then a per-channel quadratic in pressure.
// - Temperature finishes first and the same value is published and used.
// - Temperature is a cubic of four 16-bit coefficients plus an auxiliary one.
// - Each temperature channel has its own set of five coefficients.
// - Gain factor is one plus the signed 8-bit delta gain over 8192.
// - Signed 8-bit delta offset is added in output counts.
// - Post-corrected pressure is gain factor times pressure plus offset.
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
module temp_channel_map
    import tcorr_pkg::*;
(
    input  wire logic                 CLOCK,
    input  wire logic                 RESETN,
    input  wire logic                 CYC_I,
    input  wire logic                 STB_I,
    input  wire logic                 WE_I,
    input  wire logic [ADDR_W-1:0]    ADR_I,
    input  wire logic [3:0]           SEL_I,
    input  wire logic [DATA_W-1:0]    DAT_I,
    output logic      [DATA_W-1:0]    DAT_O,
    output logic                      ACK_O,
    input  wire logic                 CYCLE_START,
    output logic                      TEMP_CONVERT,
    output logic      [1:0]           TEMP_SOURCE,
    output logic      [1:0]           TEMP_RANGE,
    output logic                      PIN_A_PULLDOWN,
    input  wire logic                 TEMP_READY,
    input  wire logic [15:0]          TEMP_RAW,
    output logic signed [15:0]        T1_OUT,
    output logic signed [15:0]        T2_OUT,
    output logic                      T_OUT_VALID,
    input  wire logic                 P_VALID,
    input  wire logic [15:0]          P1_RAW,
    input  wire logic [15:0]          P2_RAW,
    output logic signed [15:0]        P1_OUT,
    output logic signed [15:0]        P2_OUT,
    output logic                      P_OUT_VALID
);
    coef_if coef ();

    coef_ram #(.WIDTH(COEF_W), .DEPTH(COEF_DEPTH)) u_ram (.clk(CLOCK), .port(coef));

    // Saturate a wide signed value to a 16-bit result
    function automatic logic signed [15:0] sat16(input logic signed [49:0] v);
        if (v > 50'sd32767) begin
            return 16'sh7FFF;
        end else if (v < -50'sd32768) begin
            return 16'sh8000;
        end
        return v[15:0];
    endfunction

    // Logarithmic input: integer part is the leading one position, fraction the bits below it
    function automatic logic [17:0] log_input(input logic [15:0] raw);
        logic [3:0]  pos;
        logic [15:0] norm;
        pos = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (raw[i]) begin
                pos = 4'(i);
            end
        end
        norm = raw << (4'hF - pos);
        return {2'b00, pos, norm[14:3]};
    endfunction

    logic [7:0]                ch1_config;
    logic [7:0]                ch2_config;
    logic [31:0]               post_corr;
    state_t                    state;
    logic                      chan;
    logic                      pjob_mode;
    logic [2:0]                pjob;
    logic [1:0]                term;
    logic [COEF_AW-1:0]        rd_addr;
    logic signed [31:0]        acc;
    logic signed [17:0]        x;
    logic [15:0]               raw_q;
    logic signed [15:0]        t_stage [2];
    logic signed [15:0]        q_stage [6];
    logic signed [15:0]        q_live [6];
    logic                      bus_wait;
    logic [1:0]                conv_count;

    // Configuration fields
    wire       diode_current_disable = ch1_config[CFG_IDIO_BIT];
    wire [1:0] ch1_source_sel        = ch1_config[CFG_SRC_LSB +: 2];
    wire [1:0] ch1_range_sel         = ch1_config[CFG_RANGE_LSB +: 2];
    wire [1:0] ch2_source_sel        = ch2_config[CFG_SRC_LSB +: 2];
    wire [1:0] ch2_range_sel         = ch2_config[CFG_RANGE_LSB +: 2];
    wire       ch2_log_formula_sel   = ch2_config[CFG_LOG_BIT];

    // Bus decode; every access is answered, unmapped reads give zero
    wire        bus_req   = CYC_I & STB_I & ~ACK_O;
    // Writes land on the edge that also shows the acknowledge to the master, never earlier
    wire        bus_write = CYC_I & STB_I & WE_I & ACK_O;
    wire        hit_coef  = ADR_I[9:8] == COEF_REGION;
    wire [31:0] cfg1_word = {24'h0, ch1_config};
    wire [31:0] cfg2_word = {24'h0, ch2_config};
    wire [31:0] stat_word = {26'h0, pjob, chan, state != ST_IDLE, 1'b0};
    wire [31:0] temp_word = {T2_OUT, T1_OUT};
    wire [31:0] pres_word = {P2_OUT, P1_OUT};
    wire [31:0] read_word = hit_coef                     ? {16'h0, coef.a_rdata} :
                            ADR_I == ADDR_CH1_CONFIG     ? cfg1_word :
                            ADR_I == ADDR_CH2_CONFIG     ? cfg2_word :
                            ADR_I == ADDR_POST_CORR      ? post_corr :
                            ADR_I == ADDR_STATUS         ? stat_word :
                            ADR_I == ADDR_TEMP_RESULT    ? temp_word :
                            ADR_I == ADDR_PRES_RESULT    ? pres_word : 32'h0000_0000;
    assign coef.a_addr  = ADR_I[COEF_AW+1:2];
    assign coef.a_wdata = DAT_I[COEF_W-1:0];
    assign coef.a_we    = bus_write & hit_coef & SEL_I[0] & SEL_I[1];
    assign coef.b_addr  = rd_addr;

    // Answer two cycles after the request so coefficient reads come out of the memory register
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            bus_wait <= 1'b0;
            ACK_O    <= 1'b0;
            DAT_O    <= 32'h0000_0000;
        end else begin
            bus_wait <= bus_req & ~bus_wait;
            ACK_O    <= bus_req & bus_wait;
            DAT_O    <= (bus_req & bus_wait) ? read_word : 32'h0000_0000;
        end
    end

    // Settings image, byte lanes honoured on the post correction word
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            ch1_config <= CFG_RESET;
            ch2_config <= CFG_RESET;
            post_corr  <= POST_RESET;
        end else begin
            if (bus_write && ADR_I == ADDR_CH1_CONFIG && SEL_I[0]) begin
                ch1_config <= DAT_I[7:0];
            end else if (bus_write && ADR_I == ADDR_CH2_CONFIG && SEL_I[0]) begin
                ch2_config <= DAT_I[7:0];
            end else if (bus_write && ADR_I == ADDR_POST_CORR) begin
                for (int b = 0; b < 4; b++) begin
                    if (SEL_I[b]) begin
                        post_corr[8*b +: 8] <= DAT_I[8*b +: 8];
                    end
                end
            end
        end
    end

    // Shared multiplier: Horner step uses x, auxiliary scaling uses the fetched coefficient
    wire signed [15:0] coef_word = coef.b_rdata;
    wire               aux_phase = state == ST_AUX;
    wire signed [17:0] mul_b     = aux_phase ? 18'(coef_word) : x;
    wire signed [49:0] product   = acc * mul_b;
    wire signed [49:0] horner    = (product >>> POLY_SHIFT) + 50'(coef_word);
    wire signed [49:0] scaled    = product >>> AUX_SHIFT;

    // Coefficient set per channel and per pressure term
    wire [5:0]  temp_base  = chan ? T2_BASE : T1_BASE;
    wire        pjob_ch2   = pjob >= PJOB_PER_CH;
    wire [2:0]  pjob_term  = pjob_ch2 ? pjob - PJOB_PER_CH : pjob;
    wire [5:0]  next_pbase = ((pjob + 3'h1) >= PJOB_PER_CH ? P2_BASE : P1_BASE)
                             + {1'b0, ((pjob + 3'h1) >= PJOB_PER_CH ? pjob + 3'h1 - PJOB_PER_CH : pjob + 3'h1), 2'b00};
    wire        use_log    = chan & ch2_log_formula_sel;
    wire [1:0]  next_src   = chan ? ch2_source_sel : ch1_source_sel;
    wire [1:0]  next_range = chan ? ch2_range_sel : ch1_range_sel;

    // Sequencer: convert channel one, then two, then derive pressure coefficients
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            state          <= ST_IDLE;
            chan           <= 1'b0;
            pjob_mode      <= 1'b0;
            pjob           <= 3'h0;
            term           <= 2'h0;
            rd_addr        <= 6'h00;
            acc            <= 32'sh0;
            x              <= 18'sh0;
            raw_q          <= 16'h0000;
            TEMP_CONVERT   <= 1'b0;
            TEMP_SOURCE    <= SRC_INT_DIODE;
            TEMP_RANGE     <= 2'h0;
            PIN_A_PULLDOWN <= 1'b0;
            T1_OUT         <= 16'sh0;
            T2_OUT         <= 16'sh0;
            T_OUT_VALID    <= 1'b0;
            for (int i = 0; i < 2; i++) begin
                t_stage[i] <= 16'sh0;
            end
            for (int i = 0; i < 6; i++) begin
                q_stage[i] <= 16'sh0;
                q_live[i]  <= 16'sh0;
            end
        end else begin
            TEMP_CONVERT <= 1'b0;
            T_OUT_VALID  <= 1'b0;
            case (state)
                ST_IDLE: begin
                    chan      <= 1'b0;
                    pjob_mode <= 1'b0;
                    if (CYCLE_START) begin
                        state <= ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    TEMP_CONVERT   <= 1'b1;
                    TEMP_SOURCE    <= next_src;
                    TEMP_RANGE     <= next_range;
                    // Pull-down only on pin a and only while it is the chosen source
                    PIN_A_PULLDOWN <= next_src == SRC_PIN_A && !diode_current_disable;
                    state          <= ST_WAIT_RAW;
                end
                ST_WAIT_RAW: begin
                    if (TEMP_READY) begin
                        raw_q   <= TEMP_RAW;
                        x       <= use_log ? log_input(TEMP_RAW) : {2'b00, TEMP_RAW};
                        rd_addr <= temp_base + {4'h0, POLY_DEGREE};
                        term    <= POLY_DEGREE;
                        state   <= ST_POLY_WAIT;
                    end
                end
                ST_POLY_WAIT: begin
                    state <= ST_POLY_ACC;
                end
                ST_POLY_ACC: begin
                    // Horner: the top term loads, each lower term multiplies and adds
                    acc <= (term == POLY_DEGREE) ? 32'(coef_word) : 32'(horner);
                    if (term != 2'h0) begin
                        term    <= term - 2'h1;
                        rd_addr <= rd_addr - 6'h01;
                        state   <= ST_POLY_WAIT;
                    end else if (!pjob_mode) begin
                        rd_addr <= temp_base + AUX_OFFSET;
                        state   <= ST_AUX_WAIT;
                    end else begin
                        q_stage[pjob] <= sat16(horner);
                        if (pjob == LAST_PJOB) begin
                            state <= ST_PUBLISH;
                        end else begin
                            pjob    <= pjob + 3'h1;
                            rd_addr <= next_pbase + {4'h0, POLY_DEGREE};
                            term    <= POLY_DEGREE;
                            state   <= ST_POLY_WAIT;
                        end
                    end
                end
                ST_AUX_WAIT: begin
                    state <= ST_AUX;
                end
                ST_AUX: begin
                    t_stage[chan] <= sat16(scaled);
                    if (!chan) begin
                        chan  <= 1'b1;
                        state <= ST_CONVERT;
                    end else begin
                        // Pressure terms only start once both temperatures are final
                        pjob_mode <= 1'b1;
                        pjob      <= 3'h0;
                        x         <= 18'(t_stage[0]);
                        rd_addr   <= P1_BASE + {4'h0, POLY_DEGREE};
                        term      <= POLY_DEGREE;
                        state     <= ST_POLY_WAIT;
                    end
                end
                ST_PUBLISH: begin
                    // Old results stay visible until the whole set is ready
                    T1_OUT      <= t_stage[0];
                    T2_OUT      <= t_stage[1];
                    T_OUT_VALID <= 1'b1;
                    for (int i = 0; i < 6; i++) begin
                        q_live[i] <= q_stage[i];
                    end
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Pressure path: quadratic in raw pressure, then post correction, three stages per channel
    wire        [15:0]      p_raw     [2];
    logic signed [31:0]     p_mid     [2];
    logic       [15:0]      p_hold    [2];
    logic signed [15:0]     p_sent    [2];
    logic signed [15:0]     p_out     [2];
    logic       [2:0]       p_valid;
    assign p_raw[0] = P1_RAW;
    assign p_raw[1] = P2_RAW;
    assign P1_OUT   = p_out[0];
    assign P2_OUT   = p_out[1];
    assign P_OUT_VALID = p_valid[2];

    for (genvar c = 0; c < 2; c++) begin : g_pres
        wire signed [7:0]  dgain   = post_corr[(c ? POST_DG2_LSB : POST_DG1_LSB) +: 8];
        wire signed [7:0]  doffs   = post_corr[(c ? POST_DO2_LSB : POST_DO1_LSB) +: 8];
        wire signed [16:0] p_in    = {1'b0, p_raw[c]};
        wire signed [16:0] p_in2   = {1'b0, p_hold[c]};
        wire signed [49:0] step1   = ((50'(q_live[3*c+2]) * 50'(p_in)) >>> POLY_SHIFT) + 50'(q_live[3*c+1]);
        wire signed [49:0] step2   = ((50'(p_mid[c]) * 50'(p_in2)) >>> POLY_SHIFT) + 50'(q_live[3*c]);
        wire signed [14:0] gfactor = 15'sd8192 + 15'(dgain);
        wire signed [49:0] post    = ((50'(p_sent[c]) * 50'(gfactor)) >>> DGAIN_SHIFT) + 50'(doffs);
        always_ff @(posedge CLOCK or negedge RESETN) begin
            if (!RESETN) begin
                p_mid[c]  <= 32'sh0;
                p_hold[c] <= 16'h0000;
                p_sent[c] <= 16'sh0;
                p_out[c]  <= 16'sh0;
            end else begin
                p_mid[c]  <= step1[31:0];
                p_hold[c] <= p_raw[c];
                p_sent[c] <= sat16(step2);
                p_out[c]  <= sat16(post);
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            p_valid <= 3'h0;
        end else begin
            p_valid <= {p_valid[1:0], P_VALID};
        end
    end

    // Helper for checks: conversions seen since the last publish
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            conv_count <= 2'h0;
        end else if (T_OUT_VALID) begin
            conv_count <= 2'h0;
        end else if (TEMP_CONVERT && conv_count != 2'h3) begin
            conv_count <= conv_count + 2'h1;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);

    sequence conv_issued;
        TEMP_CONVERT ##1 (state == ST_WAIT_RAW);
    endsequence
    sequence aux_done;
        (state == ST_AUX) && !chan ##1 (state == ST_CONVERT) && chan;
    endsequence

    both_converted_a: assert property (T_OUT_VALID |-> conv_count == 2'h2)
        else $error("publish without exactly two conversions");
    second_runs_a: assert property (aux_done |=> conv_issued)
        else $error("second channel conversion skipped");
    source_map_a: assert property (TEMP_CONVERT |-> TEMP_SOURCE == (chan ? ch2_source_sel : ch1_source_sel))
        else $error("wrong source for channel");
    pulldown_pin_a: assert property (PIN_A_PULLDOWN |-> TEMP_SOURCE == SRC_PIN_A && !diode_current_disable)
        else $error("pull-down on a pin other than a");
    ch1_linear_a: assert property ((state == ST_POLY_WAIT) && !pjob_mode && !chan |-> x == {2'b00, raw_q})
        else $error("channel one used the logarithmic input");
    pres_input_a: assert property ((state == ST_POLY_ACC) && pjob_mode |-> x == 18'(t_stage[0]))
        else $error("pressure terms not driven by channel one");
    hold_results_a: assert property (!$stable(T1_OUT) || !$stable(T2_OUT) |-> T_OUT_VALID)
        else $error("temperature result changed outside publish");
    pres_latency_a: assert property (P_VALID |-> ##3 P_OUT_VALID)
        else $error("pressure result not three cycles after sample");
    pass_through_a: assert property (p_valid[1] && post_corr == 32'h0 |=> P1_OUT == $past(p_sent[0]))
        else $error("zero post correction changed pressure");
    bus_ack_a: assert property (ACK_O |=> !ACK_O)
        else $error("acknowledge held longer than one cycle");
endmodule

// *** testbench.sv ***
// Self-checking bench for the temperature channel mapping and correction block
`timescale 1ns/1ns
module testbench;
    import tcorr_pkg::*;
    logic                CLOCK, RESETN, CYC_I, STB_I, WE_I, CYCLE_START, TEMP_READY, P_VALID;
    logic [ADDR_W-1:0]   ADR_I;
    logic [3:0]          SEL_I;
    logic [DATA_W-1:0]   DAT_I, DAT_O, rd;
    logic                ACK_O, TEMP_CONVERT, PIN_A_PULLDOWN, T_OUT_VALID, P_OUT_VALID;
    logic [1:0]          TEMP_SOURCE, TEMP_RANGE;
    logic [15:0]         TEMP_RAW, P1_RAW, P2_RAW, cw;
    logic signed [15:0]  T1_OUT, T2_OUT, P1_OUT, P2_OUT;
    int                  err_total, num_checks, cycles;

    temp_channel_map dut_u (.CLOCK(CLOCK), .RESETN(RESETN), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
        .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .CYCLE_START(CYCLE_START),
        .TEMP_CONVERT(TEMP_CONVERT), .TEMP_SOURCE(TEMP_SOURCE), .TEMP_RANGE(TEMP_RANGE),
        .PIN_A_PULLDOWN(PIN_A_PULLDOWN), .TEMP_READY(TEMP_READY), .TEMP_RAW(TEMP_RAW), .T1_OUT(T1_OUT),
        .T2_OUT(T2_OUT), .T_OUT_VALID(T_OUT_VALID), .P_VALID(P_VALID), .P1_RAW(P1_RAW), .P2_RAW(P2_RAW),
        .P1_OUT(P1_OUT), .P2_OUT(P2_OUT), .P_OUT_VALID(P_OUT_VALID));

    // Clock at 10 MHz
    always #50 CLOCK = ~CLOCK;

    // Hang guard: the whole run needs well under a few thousand cycles
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            results();
        end
    end

    task automatic results();
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Classic cycle; request held until the edge that samples ack high, data taken at that edge
    task automatic wb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge CLOCK);
        CYC_I <= 1'b1; STB_I <= 1'b1; WE_I <= w; ADR_I <= a; DAT_I <= d; SEL_I <= 4'hF;
        do @(posedge CLOCK); while (ACK_O !== 1'b1);
        rd = DAT_O;
        CYC_I <= 1'b0; STB_I <= 1'b0; WE_I <= 1'b0;
    endtask

    // Waits for a conversion request, checks the routing, then answers one cycle later
    task automatic convert(input logic [1:0] src, input logic [1:0] rng, input logic pd, input logic [15:0] raw);
        do @(negedge CLOCK); while (TEMP_CONVERT !== 1'b1);
        chk("source", {30'h0, src}, {30'h0, TEMP_SOURCE});
        chk("range", {30'h0, rng}, {30'h0, TEMP_RANGE});
        chk("pulldown", {31'h0, pd}, {31'h0, PIN_A_PULLDOWN});
        @(posedge CLOCK);
        TEMP_READY <= 1'b1; TEMP_RAW <= raw;
        @(posedge CLOCK);
        TEMP_READY <= 1'b0; TEMP_RAW <= ~raw;
    endtask

    task automatic pressure(input logic [15:0] e1, input logic [15:0] e2);
        @(posedge CLOCK);
        P_VALID <= 1'b1; P1_RAW <= 16'h2000; P2_RAW <= 16'h5000;
        @(posedge CLOCK);
        P_VALID <= 1'b0; P1_RAW <= 16'hDFFF; P2_RAW <= 16'hAFFF;
        do @(negedge CLOCK); while (P_OUT_VALID !== 1'b1);
        chk("p1_out", {16'h0, e1}, {16'h0, P1_OUT});
        chk("p2_out", {16'h0, e2}, {16'h0, P2_OUT});
    endtask

    initial begin
        {CLOCK, CYC_I, STB_I, WE_I, CYCLE_START, TEMP_READY, P_VALID} = '0;
        {ADR_I, SEL_I, DAT_I, TEMP_RAW, P1_RAW, P2_RAW} = '0;
        {err_total, num_checks, cycles} = '0;
        RESETN = 1'b0;
        repeat (2) @(posedge CLOCK);
        RESETN <= 1'b1;
        // Reset values, then an unmapped place that must read zero and swallow writes
        wb(1'b0, ADDR_CH1_CONFIG, '0); chk("ch1_cfg_rst", 32'h0, rd);
        wb(1'b0, ADDR_CH2_CONFIG, '0); chk("ch2_cfg_rst", 32'h0, rd);
        wb(1'b0, ADDR_POST_CORR, '0); chk("post_rst", 32'h0, rd);
        wb(1'b1, 10'h0F0, 32'hFFFF_FFFF);
        wb(1'b0, 10'h0F0, '0); chk("unmapped", 32'h0, rd);
        wb(1'b1, ADDR_CH1_CONFIG, 32'h0000_0005);
        wb(1'b1, ADDR_CH2_CONFIG, 32'h0000_000B);
        wb(1'b0, ADDR_CH2_CONFIG, '0); chk("ch2_cfg", 32'h0000_000B, rd);
        // Constant-only coefficient sets, unity auxiliary term, distinct per channel
        for (int i = 0; i < 48; i++) begin
            cw = (i == 0) ? 16'h0100 : (i == 8) ? 16'h0200 : (i == 4 || i == 12) ? 16'h4000 :
                 (i == 16) ? 16'h0300 : (i == 32) ? 16'h0400 : 16'h0000;
            wb(1'b1, ADDR_COEF_BASE + ADDR_W'(4 * i), {16'h0, cw});
        end
        @(posedge CLOCK);
        CYCLE_START <= 1'b1;
        @(posedge CLOCK);
        CYCLE_START <= 1'b0;
        convert(SRC_PIN_A, 2'h1, 1'b1, 16'h1234);
        convert(SRC_PIN_B, 2'h3, 1'b0, 16'h4321);
        do @(negedge CLOCK); while (T_OUT_VALID !== 1'b1);
        chk("t1_out", 32'h0100, {16'h0, T1_OUT});
        chk("t2_out", 32'h0200, {16'h0, T2_OUT});
        wb(1'b0, ADDR_TEMP_RESULT, '0); chk("temp_reg", 32'h0200_0100, rd);
        pressure(16'h0300, 16'h0400);
        // Offset of -1 on p1, delta gain 127 on p2: 1024*8319>>13 = 1039
        wb(1'b1, ADDR_POST_CORR, 32'h007F_FF00);
        pressure(16'h02FF, 16'h040F);
        wb(1'b0, ADDR_PRES_RESULT, '0); chk("pres_reg", 32'h040F_02FF, rd);
        chk("t1_hold", 32'h0100, {16'h0, T1_OUT});
        // Second cycle: logarithmic input on channel two with a linear term, x = 0xE0C8
        wb(1'b1, ADDR_CH2_CONFIG, 32'h0000_001B);
        wb(1'b1, ADDR_COEF_BASE + 10'h024, 32'h0000_4000);
        wb(1'b0, ADDR_COEF_BASE + 10'h024, '0); chk("coef_rd", 32'h0000_4000, rd);
        @(posedge CLOCK);
        CYCLE_START <= 1'b1;
        @(posedge CLOCK);
        CYCLE_START <= 1'b0;
        convert(SRC_PIN_A, 2'h1, 1'b1, 16'h1234);
        convert(SRC_PIN_B, 2'h3, 1'b0, 16'h4321);
        do @(negedge CLOCK); while (T_OUT_VALID !== 1'b1);
        chk("t2_log", 32'h7264, {16'h0, T2_OUT});
        chk("t1_again", 32'h0100, {16'h0, T1_OUT});
        results();
    end
endmodule
